/* File: src/qps_pkg.sv */
// qps_pkg: constants, opcodes and carrier types for the quad pot command framer.
// assumes a byte-framed serial link, msb first, select active low.
package qps_pkg;
    // array shape
    localparam int POTS = 4;
    localparam int REGS = 4;
    localparam int VW   = 6;

    // instruction opcodes (upper nibble of the second byte)
    localparam logic [3:0] OP_RD_STORE = 4'hB;
    localparam logic [3:0] OP_WR_STORE = 4'hC;
    localparam logic [3:0] OP_COPY_SW  = 4'hD;
    localparam logic [3:0] OP_COPY_WS  = 4'hE;
    localparam logic [3:0] OP_GCOPY_SW = 4'h1;
    localparam logic [3:0] OP_GCOPY_WS = 4'h8;
    localparam logic [3:0] OP_STEP     = 4'h2;
    localparam logic [7:0] INS_STATUS  = 8'h51;

    // bit counter milestones (bits already taken)
    localparam logic [4:0] CNT_ID_LAST   = 5'h07;
    localparam logic [4:0] CNT_INS_LAST  = 5'h0F;
    localparam logic [4:0] CNT_DATA_FST  = 5'h10;
    localparam logic [4:0] CNT_DATA_LAST = 5'h17;
    localparam logic [4:0] CNT_MAX       = 5'h18;

    // values after reset
    localparam logic [VW-1:0] STORE_RESET = 6'h00;

    // nonvolatile write time and its count of clk cycles
    localparam int CLK_PERIOD_NS   = 25;
    localparam int T_NV_WRITE_NS   = 5_000_000;
    localparam int NV_WRITE_CYCLES = T_NV_WRITE_NS / CLK_PERIOD_NS;

    typedef logic [VW-1:0] qps_val_t;

    // command handed from the link domain to the core
    typedef struct packed {
        logic [3:0] op;
        logic [1:0] rs;
        logic [1:0] pot;
        qps_val_t   data;
    } qps_cmd_t;
endpackage

/* File: src/qps_cmd_frames.sv */
// qps_cmd_frames: serial command framer and executor for four wipers with four
// stored settings each. link logic runs on sck; storage and wipers run on clk.
// assumes sck only toggles while cs_n is low and storage is never altered mid-frame.
`timescale 1ns/1ps
module qps_cmd_frames #(
    parameter logic [3:0] DEV_ID          = 4'hA, // arbitrary value
    parameter int         NV_WRITE_CYCLES = qps_pkg::NV_WRITE_CYCLES
) (
    // core clock and reset
    input  wire logic                                       clk,
    input  wire logic                                       rst_n,
    // serial link
    input  wire logic                                       sck,
    input  wire logic                                       cs_n,
    input  wire logic                                       si,
    output logic                                            so,
    output logic                                            so_oe,
    // straps and status
    input  wire logic [1:0]                                 chip_address_bits,
    output logic                                            write_busy_flag,
    output logic [qps_pkg::POTS-1:0][qps_pkg::VW-1:0]       wiper_position_register
);
    // clk domain storage
    logic                                                   rst_s1_q, rst_q;
    logic                                                   cs_s1_q, cs_s2_q;
    logic                                                   tog_s1_q, tog_s2_q, tog_s3_q;
    logic                                                   pend_q;
    logic [$clog2(NV_WRITE_CYCLES+1)-1:0]                   nv_cnt_q;
    logic [qps_pkg::POTS-1:0][qps_pkg::REGS-1:0][qps_pkg::VW-1:0] stored_setting_register;
    logic [qps_pkg::POTS-1:0][qps_pkg::VW-1:0]              wiper_q;
    // sck domain
    logic [4:0]                                             cnt_q;
    logic [6:0]                                             sh_q;
    logic [7:0]                                             ins_q;
    logic [7:0]                                             out_q;
    logic                                                   active_q, issued_q;
    logic [1:0]                                             addr_s1_q, addr_s2_q;
    logic                                                   busy_s1_q, busy_s2_q;
    qps_pkg::qps_val_t                                      step_q;
    qps_pkg::qps_cmd_t                                      cmd_q;
    logic                                                   tog_q;
    logic                                                   so_q, so_oe_q;

    // link decode: the byte being completed this edge, and the live instruction
    wire [7:0] byte_in  = {sh_q, si};
    wire       ins_now  = (cnt_q == qps_pkg::CNT_INS_LAST);
    wire [7:0] ins      = ins_now ? byte_in : ins_q;
    wire [3:0] op       = ins[7:4];
    wire [1:0] rs       = ins[3:2];
    wire [1:0] pot      = ins[1:0];
    wire       id_ok    = (byte_in == {DEV_ID, 2'b00, addr_s2_q});
    wire       is_two   = (op == qps_pkg::OP_COPY_SW) || (op == qps_pkg::OP_COPY_WS)
                        || (((op == qps_pkg::OP_GCOPY_SW) || (op == qps_pkg::OP_GCOPY_WS))
                            && (pot == 2'b00));
    wire       is_wr    = (op == qps_pkg::OP_WR_STORE);
    wire       is_step  = (op == qps_pkg::OP_STEP);
    wire       is_read  = (op == qps_pkg::OP_RD_STORE) || (ins == qps_pkg::INS_STATUS);
    wire       in_data  = (cnt_q >= qps_pkg::CNT_DATA_FST);
    wire       stepping = active_q && is_step && in_data;
    // core reset also clears the link: a select held high from power-up never rises
    wire       frame_clr = cs_n || !rst_q;
    wire [7:0] rd_val   = (op == qps_pkg::OP_RD_STORE)
                        ? {2'b00, stored_setting_register[pot][rs]}
                        : {7'h00, busy_s2_q};
    // wiper saturates at both ends of the array
    wire qps_pkg::qps_val_t step_nxt = si ? ((&step_q) ? step_q : step_q + 6'h01)
                                          : ((~|step_q) ? step_q : step_q - 6'h01);
    wire       issue    = active_q && !issued_q
                        && ((is_two && ins_now)
                            || (is_wr && cnt_q == qps_pkg::CNT_DATA_LAST)
                            || stepping);

    // frame state: cleared by select going high so a new frame starts clean
    always_ff @(posedge sck or posedge frame_clr) begin
        if (frame_clr) begin
            cnt_q     <= 5'h00;
            sh_q      <= 7'h00;
            ins_q     <= 8'h00;
            out_q     <= 8'h00;
            active_q  <= 1'b1;
            issued_q  <= 1'b0;
            step_q    <= qps_pkg::STORE_RESET;
        end else begin
            cnt_q     <= (cnt_q == qps_pkg::CNT_MAX) ? cnt_q : cnt_q + 5'h01;
            sh_q      <= byte_in[6:0];
            if (cnt_q == qps_pkg::CNT_ID_LAST && !id_ok) begin
                active_q <= 1'b0;
            end
            if (issue) begin
                issued_q <= 1'b1;
            end
            if (ins_now) begin
                ins_q  <= byte_in;
                out_q  <= rd_val;
                step_q <= wiper_q[pot];
            end else begin
                out_q  <= {out_q[6:0], 1'b0};
                if (stepping) begin
                    step_q <= step_nxt;
                end
            end
        end
    end

    // straps and busy flag are sampled on the link clock before use
    always_ff @(posedge sck or negedge rst_q) begin
        if (!rst_q) begin
            addr_s1_q <= 2'b00;
            addr_s2_q <= 2'b00;
            busy_s1_q <= 1'b0;
            busy_s2_q <= 1'b0;
        end else begin
            addr_s1_q <= chip_address_bits;
            addr_s2_q <= addr_s1_q;
            busy_s1_q <= write_busy_flag;
            busy_s2_q <= busy_s1_q;
        end
    end

    // command hand-off: at most one toggle per frame; step data keeps updating behind it
    always_ff @(posedge sck or negedge rst_q) begin
        if (!rst_q) begin
            tog_q <= 1'b0;
            cmd_q <= '0;
        end else if (issue) begin
            tog_q      <= ~tog_q;
            cmd_q.op   <= op;
            cmd_q.rs   <= rs;
            cmd_q.pot  <= pot;
            cmd_q.data <= is_step ? step_nxt : byte_in[5:0];
        end else if (stepping) begin
            cmd_q.data <= step_nxt;
        end
    end

    // output drive on the falling edge, released whenever the frame is not ours
    always_ff @(negedge sck or posedge frame_clr) begin
        if (frame_clr) begin
            so_q    <= 1'b0;
            so_oe_q <= 1'b0;
        end else begin
            so_q    <= out_q[7];
            so_oe_q <= active_q && is_read && in_data;
        end
    end

    assign so    = so_q;
    assign so_oe = so_oe_q;

    // reset release, select and toggle synchronisers on clk
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_s1_q <= 1'b0;
            rst_q    <= 1'b0;
        end else begin
            rst_s1_q <= 1'b1;
            rst_q    <= rst_s1_q;
        end
    end

    always_ff @(posedge clk or negedge rst_q) begin
        if (!rst_q) begin
            cs_s1_q  <= 1'b1;
            cs_s2_q  <= 1'b1;
            tog_s1_q <= 1'b0;
            tog_s2_q <= 1'b0;
            tog_s3_q <= 1'b0;
        end else begin
            cs_s1_q  <= cs_n;
            cs_s2_q  <= cs_s1_q;
            tog_s1_q <= tog_q;
            tog_s2_q <= tog_s1_q;
            tog_s3_q <= tog_s2_q;
        end
    end

    // execution waits for select high, so cmd_q has settled and the frame is complete
    wire tog_evt  = tog_s2_q ^ tog_s3_q;
    wire exec     = pend_q && cs_s2_q;
    wire busy     = (nv_cnt_q != '0);
    wire c_wr     = exec && cmd_q.op == qps_pkg::OP_WR_STORE && !busy;
    wire c_xdw    = exec && cmd_q.op == qps_pkg::OP_COPY_SW;
    wire c_xwd    = exec && cmd_q.op == qps_pkg::OP_COPY_WS && !busy;
    wire c_gdw    = exec && cmd_q.op == qps_pkg::OP_GCOPY_SW;
    wire c_gwd    = exec && cmd_q.op == qps_pkg::OP_GCOPY_WS && !busy;
    wire c_step   = exec && cmd_q.op == qps_pkg::OP_STEP;
    wire nv_start = c_wr || c_xwd || c_gwd;

    // pending flag: a new event wins over the clear of the old one
    always_ff @(posedge clk or negedge rst_q) begin
        if (!rst_q) begin
            pend_q   <= 1'b0;
            nv_cnt_q <= '0;
        end else begin
            pend_q <= tog_evt || (pend_q && !exec);
            if (nv_start) begin
                nv_cnt_q <= ($clog2(NV_WRITE_CYCLES+1))'(NV_WRITE_CYCLES);
            end else if (busy) begin
                nv_cnt_q <= nv_cnt_q - 1'b1;
            end
        end
    end

    assign write_busy_flag = busy;

    // storage and wipers; reset loads STORE_RESET into every wiper and every stored setting
    always_ff @(posedge clk or negedge rst_q) begin
        if (!rst_q) begin
            stored_setting_register <= {(qps_pkg::POTS*qps_pkg::REGS){qps_pkg::STORE_RESET}};
            wiper_q                 <= {qps_pkg::POTS{qps_pkg::STORE_RESET}};
        end else begin
            if (c_wr) begin
                stored_setting_register[cmd_q.pot][cmd_q.rs] <= cmd_q.data;
            end
            if (c_xwd) begin
                stored_setting_register[cmd_q.pot][cmd_q.rs] <= wiper_q[cmd_q.pot];
            end
            if (c_xdw) begin
                wiper_q[cmd_q.pot] <= stored_setting_register[cmd_q.pot][cmd_q.rs];
            end
            if (c_step) begin
                wiper_q[cmd_q.pot] <= cmd_q.data;
            end
            for (int p = 0; p < qps_pkg::POTS; p++) begin
                if (c_gdw) begin
                    wiper_q[p] <= stored_setting_register[p][cmd_q.rs];
                end
                if (c_gwd) begin
                    stored_setting_register[p][cmd_q.rs] <= wiper_q[p];
                end
            end
        end
    end

    assign wiper_position_register = wiper_q;
endmodule

/* File: dv/qps_props.sv */
// qps_props: timing checks on the quad pot framer ports.
// assumes it is bound to the framer and that sck runs only inside frames.
`timescale 1ns/1ps
module qps_props #(
    parameter logic [3:0] DEV_ID = 4'hA // arbitrary value
) (
    // clocks and reset
    input wire logic                                 clk,
    input wire logic                                 rst_n,
    // serial link
    input wire logic                                 sck,
    input wire logic                                 cs_n,
    input wire logic                                 si,
    input wire logic                                 so,
    input wire logic                                 so_oe,
    // straps and status
    input wire logic [1:0]                           chip_address_bits,
    input wire logic                                 write_busy_flag,
    input wire logic [qps_pkg::POTS-1:0][qps_pkg::VW-1:0] wiper_position_register
);
    logic [4:0]  n_q;
    logic [15:0] sh_q;
    logic        at_data;
    logic        hit;
    // bits taken this frame; select high clears it just as the link does
    always_ff @(posedge sck or posedge cs_n) begin
        if (cs_n) begin
            n_q <= 5'h00;
        end else begin
            n_q <= n_q + 5'h01;
        end
    end
    // no clear needed: only read once 16 fresh bits are in
    always_ff @(posedge sck) begin
        sh_q <= {sh_q[14:0], si};
    end
    assign at_data = n_q == 5'h10;
    assign hit     = at_data && sh_q[15:8] == {DEV_ID, 2'b00, chip_address_bits};

    a_oe_idle_low: assert property (@(posedge clk) disable iff (!rst_n)
        cs_n |-> !so_oe) else $error("so_oe high with select idle");
    a_busy_hold: assert property (@(posedge clk) disable iff (!rst_n)
        $rose(write_busy_flag) |-> write_busy_flag [*8]) else $error("busy too short");
    a_busy_after_frame: assert property (@(posedge clk) disable iff (!rst_n)
        $rose(write_busy_flag) |-> cs_n && $past(cs_n, 2)) else $error("busy inside frame");
    a_lead_zeros: assert property (@(posedge sck) disable iff (!rst_n)
        $rose(so_oe) |-> !so ##1 !so) else $error("read byte lacks two leading zeros");
    a_oe_eight_bits: assert property (@(posedge sck) disable iff (!rst_n)
        $rose(so_oe) |-> so_oe [*8]) else $error("answer shorter than a byte");
    a_foreign_silent: assert property (@(posedge sck) disable iff (!rst_n)
        at_data && !hit |-> !so_oe ##1 !so_oe) else $error("answer to foreign frame");
    a_read_drives: assert property (@(posedge sck) disable iff (!rst_n)
        hit && sh_q[7:4] == qps_pkg::OP_RD_STORE |-> so_oe) else $error("read not answered");
    a_status_zeros: assert property (@(posedge sck) disable iff (!rst_n)
        hit && sh_q[7:0] == qps_pkg::INS_STATUS |-> so_oe && (!so) [*7])
        else $error("status upper bits not zero");
endmodule

/* File: dv/qps_spi_master.sv */
// qps_spi_master: behavioural serial master that frames commands for the framer.
// assumes one caller at a time; link clock is parked low between frames.
`timescale 1ns/1ps
module qps_spi_master (
    // serial link
    output logic      sck,
    output logic      cs_n,
    output logic      si,
    input  wire logic so,
    input  wire logic so_oe
);
    // idle link: clock still, select high
    initial begin
        sck  = 1'b0;
        cs_n = 1'b1;
        si   = 1'b0;
    end
    // top n bits of f, msb first, on a 6 ns clock; so taken at risings 17 to 24
    task automatic xfer(input logic [31:0] f, input int n, output logic [7:0] rd,
                        output logic oe);
        rd   = 8'h00;
        oe   = 1'b0;
        cs_n = 1'b0;
        for (int i = 0; i < n; i++) begin
            si = f[31-i];
            #3 sck = 1'b1;
            rd = (i >= 16 && i < 24) ? {rd[6:0], so} : rd;
            oe = oe | so_oe;
            #3 sck = 1'b0;
        end
        #3 cs_n = 1'b1;
        si = ~si; // released line must not keep showing the last bit
    endtask
endmodule

/* File: dv/testbench.sv */
// testbench: frames commands through the serial master and checks wipers,
// stored settings, status and busy; assumes the framer's core clock is clk.
`timescale 1ns/1ps
module testbench;
    localparam logic [3:0] DID = 4'h6; // arbitrary value
    localparam logic [1:0] AD  = 2'b10;
    logic        clk, rst_n, sck, cs_n, si, so, so_oe, busy, oe;
    logic [23:0] wp, obs, exp_q[$];
    logic [15:0] tl;
    logic [7:0]  rd;
    logic [5:0]  st[4], mw[4];
    string       nm_q[$];
    int          err_total, total_checks, seed;
    event        seen;

    qps_cmd_frames #(.DEV_ID(DID), .NV_WRITE_CYCLES(20)) dut (.clk, .rst_n, .sck, .cs_n,
        .si, .so, .so_oe, .chip_address_bits(AD), .write_busy_flag(busy),
        .wiper_position_register(wp));
    qps_spi_master u_mst (.sck, .cs_n, .si, .so, .so_oe);

    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    task automatic chk(input logic [23:0] s, e, input string what);
        total_checks++;
        if (s !== e) begin
            err_total++;
            $display("[FAIL] %s expected %h seen %h", what, e, s);
        end
    endtask
    task automatic conclude;
        $display("checks %0d mismatches %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    // queue the expectation, hand the observation to the monitor
    task automatic note(input logic [23:0] e, o, input string what);
        exp_q.push_back(e);
        nm_q.push_back(what);
        obs = o;
        -> seen;
        #0;
    endtask
    initial forever begin
        @(seen);
        chk(obs, exp_q.pop_front(), nm_q.pop_front());
    end
    // one frame, then the fixed settle the core needs after select rises
    task automatic cmd(input logic [7:0] ins, input logic [15:0] t, input int n,
                       input logic [1:0] a);
        u_mst.xfer({DID, 2'b00, a, ins, t}, n, rd, oe);
        repeat (8) @(posedge clk);
        #2;
    endtask
    task automatic rds(input logic [1:0] r, p, input logic [5:0] v, input string w);
        cmd({qps_pkg::OP_RD_STORE, r, p}, 16'h0000, 24, AD);
        note({18'h0, v}, {16'h0, rd}, w);
    endtask
    task automatic idle;
        for (int i = 0; i < 60 && busy !== 1'b0; i++) @(posedge clk);
        #2 note(24'h0, {23'h0, busy}, "busy clear");
    endtask

    initial begin
        seed = 32'h0f27_6e51;
        err_total = 0;
        total_checks = 0;
        rst_n = 1'b0;
        repeat (2) @(posedge clk);
        #2 rst_n = 1'b1;
        repeat (4) @(posedge clk);
        #2 note(24'h0, wp, "wiper reset");
        // slot 2 of each pot: write, status while busy, read back
        for (int p = 0; p < 4; p++) begin
            st[p] = 6'($random(seed));
            mw[p] = st[p];
            cmd({qps_pkg::OP_WR_STORE, 2'h2, 2'(p)}, {2'b00, st[p], 8'h00}, 24, AD);
            cmd(qps_pkg::INS_STATUS, 16'h0000, 24, AD);
            note(24'h1, {16'h0, rd}, "status busy");
            idle();
            rds(2'h2, 2'(p), st[p], "stored read");
        end
        $display("test write and read done");
        cmd({qps_pkg::OP_GCOPY_SW, 2'h2, 2'b00}, 16'h0000, 16, AD);
        note({mw[3], mw[2], mw[1], mw[0]}, wp, "global load");
        // random direction bits on pot 1, saturating at both ends
        tl = 16'($random(seed));
        cmd({qps_pkg::OP_STEP, 2'b00, 2'h1}, tl, 32, AD);
        for (int i = 15; i >= 0; i--) begin
            mw[1] = tl[i] ? mw[1] + 6'(mw[1] != 6'h3f) : mw[1] - 6'(mw[1] != 6'h00);
        end
        note({mw[3], mw[2], mw[1], mw[0]}, wp, "steps");
        cmd({qps_pkg::OP_COPY_WS, 2'h0, 2'h1}, 16'h0000, 16, AD);
        note(24'h1, {23'h0, busy}, "save busy");
        idle();
        rds(2'h0, 2'h1, mw[1], "saved wiper");
        mw[1] = st[1];
        cmd({qps_pkg::OP_COPY_SW, 2'h2, 2'h1}, 16'h0000, 16, AD);
        note({mw[3], mw[2], mw[1], mw[0]}, wp, "recall");
        note(24'h0, {23'h0, busy}, "recall busy");
        $display("test copy done");
        cmd({qps_pkg::OP_GCOPY_WS, 2'h3, 2'b00}, 16'h0000, 16, AD);
        note(24'h1, {23'h0, busy}, "global save busy");
        idle();
        rds(2'h3, 2'h3, mw[3], "global save");
        // foreign address: no load and no answer
        cmd({qps_pkg::OP_GCOPY_SW, 2'h0, 2'b00}, 16'h0000, 16, ~AD);
        note({mw[3], mw[2], mw[1], mw[0]}, wp, "foreign load");
        cmd({qps_pkg::OP_RD_STORE, 2'h2, 2'h0}, 16'h0000, 24, ~AD);
        note(24'h0, {23'h0, oe}, "foreign oe");
        $display("test global and address done");
        conclude();
    end
    // watchdog well past the expected run of some 10 us
    initial begin
        #200_000;
        err_total++;
        conclude();
    end
endmodule
bind qps_cmd_frames qps_props #(.DEV_ID(DEV_ID)) u_props (.clk, .rst_n, .sck, .cs_n, .si,
    .so, .so_oe, .chip_address_bits, .write_busy_flag, .wiper_position_register);
